// >>> tcu_pkg.sv
/*
 * Shared constants of the timer capture unit: register offsets, field
 * positions, reset values, capture mode codes and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus with byte addressing.
 */
package tcu_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;  // unit_control_reg
  localparam logic [7:0] OFS_CAPTURE = 8'h04;  // capture_value_pair
  localparam logic [7:0] OFS_STATUS  = 8'h08;  // periph_flag_reg_one, read only
  localparam logic [7:0] OFS_CLEAR   = 8'h0C;  // write one to clear status
  localparam logic [7:0] OFS_ENABLE  = 8'h10;  // periph_enable_reg_one
  localparam logic [7:0] OFS_DIR     = 8'h14;  // port_c_direction
  localparam logic [7:0] OFS_DATA    = 8'h18;  // port_c_data

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 3;
  localparam int FLAG_BIT = 2;  // capture_irq_flag / capture_irq_enable
  localparam int PIN_BIT  = 2;  // capture pin within the port registers

  // ****************************************
  // Capture modes of capture_mode_select
  // ****************************************
  localparam logic [3:0] MODE_FALL    = 4'h4;
  localparam logic [3:0] MODE_RISE    = 4'h5;
  localparam logic [3:0] MODE_RISE4   = 4'h6;
  localparam logic [3:0] MODE_RISE16  = 4'h7;
  localparam logic [3:0] DIV4_LAST    = 4'h3;
  localparam logic [3:0] DIV16_LAST   = 4'hF;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0]  CTRL_RST = 4'h0;
  localparam logic        EN_RST   = 1'b0;
  localparam logic        DIR_RST  = 1'b1;  // Pin starts as input
  localparam logic        DATA_RST = 1'b0;
  localparam logic [15:0] CAP_RST  = 16'h0000;

  // ****************************************
  // Bus responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage

// >>> tcu_edge_qual.sv
/*
 * Edge qualifier: synchronises the capture pin, picks pin or port latch
 * as source, detects edges and prescales rising edges per mode.
 * Assumes mode and mode_chg come from logic on the same clock.
 */
`timescale 1ns/1ps
module tcu_edge_qual (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       pin_in,
  input  wire logic       drive_en,
  input  wire logic       drive_level,
  input  wire logic [3:0] mode,
  input  wire logic       mode_chg,
  output logic            event_pulse
);

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       prev;
    logic [3:0] cnt;
    logic       evt;
  } tcu_eq_state_t;

  localparam tcu_eq_state_t EQ_RST = '{sync1: 1'b0, sync2: 1'b0, prev: 1'b0,
                                       cnt: 4'h0, evt: 1'b0};

  tcu_eq_state_t s_reg;
  tcu_eq_state_t s_next;
  logic          src;
  logic          rise;
  logic          fall;

  // ****************************************
  // Edge detection and prescaler
  // ****************************************
  // Output mode watches the port latch so a data write can capture
  assign src  = drive_en ? drive_level : s_reg.sync2;  // RQ8
  assign rise = src && !s_reg.prev;  // RQ14
  assign fall = !src && s_reg.prev;  // RQ14

  always_comb begin
    s_next       = s_reg;
    s_next.sync1 = pin_in;
    s_next.sync2 = s_reg.sync1;  // RQ14
    s_next.prev  = src;
    s_next.evt   = 1'b0;
    if (rise) begin
      s_next.cnt = s_reg.cnt + 4'h1;  // RQ14
    end
    case (mode)  // RQ3
      tcu_pkg::MODE_FALL:   s_next.evt = fall;  // RQ2
      tcu_pkg::MODE_RISE:   s_next.evt = rise;  // RQ2
      tcu_pkg::MODE_RISE4:  s_next.evt = rise && (s_reg.cnt[1:0] == tcu_pkg::DIV4_LAST[1:0]);
      tcu_pkg::MODE_RISE16: s_next.evt = rise && (s_reg.cnt == tcu_pkg::DIV16_LAST);  // RQ2
      default:              s_next.cnt = 4'h0;
    endcase
    // Restart the prescaler on a new mode; an edge in flight may still fire
    if (mode_chg) begin
      s_next.cnt = 4'h0;  // RQ11
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= EQ_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign event_pulse = s_reg.evt;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_fall_event: assert property ((mode == tcu_pkg::MODE_FALL) && fall |=> event_pulse) // RQ2
    else $error("falling edge did not capture");
  a_div4_event: assert property ((mode == tcu_pkg::MODE_RISE4) && rise && !mode_chg
                                 && (s_reg.cnt[1:0] == 2'h3) |=> event_pulse) // RQ2
    else $error("fourth rising edge did not capture");
  a_div16_quiet: assert property ((mode == tcu_pkg::MODE_RISE16) && (s_reg.cnt != 4'hF)
                                  |=> !event_pulse) // RQ14
    else $error("divide by sixteen captured early");
  a_mode_restart: assert property (mode_chg |=> s_reg.cnt == 4'h0) // RQ11
    else $error("prescaler not restarted on mode change");

endmodule

// >>> tcu_top.sv
/*
 * Timer capture unit top: AXI4-Lite register slave, capture register,
 * sticky capture flag with interrupt gating, and capture pin driver.
 * Assumes companion_timer_count is on aclk; the pin is asynchronous.
 */
`timescale 1ns/1ps
// Behaviour
// RQ1: Event copies full 16-bit timer into capture
// RQ2: Events: fall, rise, fourth rise, sixteenth rise
// RQ3: Mode select field picks event type
// RQ4: Every capture sets the capture flag
// RQ5: Only software clears the capture flag
// RQ6: New capture overwrites unread capture value
// RQ7: Software sets pin as input for capture
// RQ8: Port write on output pin may capture
// RQ9: Software keeps timer in synchronous modes
// RQ10: Asynchronous timer mode captures are not guaranteed
// RQ11: Mode change may raise a false capture
// RQ12: Software masks and clears flag around changes
// RQ13: Flag sets regardless of interrupt enables
// RQ14: Pin synchronised; prescaler counts rising edges
module tcu_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [15:0]       companion_timer_count,
  input  wire logic              capture_input_pin_i,
  output logic                   capture_input_pin_o,
  output logic                   capture_input_pin_oe,
  output logic                   irq
);

  typedef struct packed {
    logic        aw_full;
    logic [7:0]  awaddr;
    logic        awready;
    logic        w_full;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  mode;
    logic        mode_chg;
    logic [15:0] cap;
    logic        flag;
    logic        ien;
    logic        dir;
    logic        dout;
    logic        pin_oe;
    logic        pin_out;
    logic        irq;
  } tcu_top_state_t;

  localparam tcu_top_state_t TOP_RST = '{
    aw_full: 1'b0, awaddr: 8'h00, awready: 1'b1,
    w_full: 1'b0, wdata: 32'h0000_0000, wstrb: 4'h0, wready: 1'b1,
    bvalid: 1'b0, bresp: tcu_pkg::RESP_OKAY,
    arready: 1'b1, rvalid: 1'b0, rdata: 32'h0000_0000, rresp: tcu_pkg::RESP_OKAY,
    mode: tcu_pkg::CTRL_RST, mode_chg: 1'b0, cap: tcu_pkg::CAP_RST,
    flag: 1'b0, ien: tcu_pkg::EN_RST, dir: tcu_pkg::DIR_RST,
    dout: tcu_pkg::DATA_RST, pin_oe: 1'b0, pin_out: tcu_pkg::DATA_RST, irq: 1'b0};

  tcu_top_state_t s_reg;
  tcu_top_state_t s_next;
  logic           cap_event;
  logic           clr_hit;
  logic           wr_do;

  // ****************************************
  // Edge qualifier
  // ****************************************
  tcu_edge_qual u_edge (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .pin_in      (capture_input_pin_i),
    .drive_en    (s_reg.pin_oe),
    .drive_level (s_reg.pin_out),
    .mode        (s_reg.mode),
    .mode_chg    (s_reg.mode_chg),
    .event_pulse (cap_event)
  );

  // ****************************************
  // Register read mux
  // ****************************************
  function automatic logic [31:0] read_word(input tcu_top_state_t st, input logic [7:0] a);
    logic [31:0] v;
    v = tcu_pkg::RDATA_ZERO;
    if (a == tcu_pkg::OFS_CTRL) begin
      v[tcu_pkg::MODE_MSB:tcu_pkg::MODE_LSB] = st.mode;
    end else if (a == tcu_pkg::OFS_CAPTURE) begin
      v[15:0] = st.cap;
    end else if (a == tcu_pkg::OFS_STATUS) begin
      v[tcu_pkg::FLAG_BIT] = st.flag;
    end else if (a == tcu_pkg::OFS_ENABLE) begin
      v[tcu_pkg::FLAG_BIT] = st.ien;
    end else if (a == tcu_pkg::OFS_DIR) begin
      v[tcu_pkg::PIN_BIT] = st.dir;
    end else if (a == tcu_pkg::OFS_DATA) begin
      v[tcu_pkg::PIN_BIT] = st.dout;
    end
    return v;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == tcu_pkg::OFS_CTRL) || (a == tcu_pkg::OFS_CAPTURE)
        || (a == tcu_pkg::OFS_STATUS) || (a == tcu_pkg::OFS_CLEAR)
        || (a == tcu_pkg::OFS_ENABLE) || (a == tcu_pkg::OFS_DIR)
        || (a == tcu_pkg::OFS_DATA);
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  assign wr_do   = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
  assign clr_hit = wr_do && (s_reg.awaddr == tcu_pkg::OFS_CLEAR) && s_reg.wstrb[0]
                   && s_reg.wdata[tcu_pkg::FLAG_BIT];

  always_comb begin
    s_next          = s_reg;
    s_next.mode_chg = 1'b0;

    // Write response retires first so a new one may start next cycle
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (wr_do) begin
      s_next.aw_full = 1'b0;
      s_next.w_full  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = addr_mapped(s_reg.awaddr) ? tcu_pkg::RESP_OKAY : tcu_pkg::RESP_SLVERR;
      // All fields live in byte lane 0; other lanes are ignored
      if (s_reg.wstrb[0]) begin
        if (s_reg.awaddr == tcu_pkg::OFS_CTRL) begin
          s_next.mode     = s_reg.wdata[tcu_pkg::MODE_MSB:tcu_pkg::MODE_LSB];  // RQ3
          s_next.mode_chg = s_next.mode != s_reg.mode;  // RQ11
        end else if (s_reg.awaddr == tcu_pkg::OFS_ENABLE) begin
          s_next.ien = s_reg.wdata[tcu_pkg::FLAG_BIT];
        end else if (s_reg.awaddr == tcu_pkg::OFS_DIR) begin
          s_next.dir = s_reg.wdata[tcu_pkg::PIN_BIT];
        end else if (s_reg.awaddr == tcu_pkg::OFS_DATA) begin
          s_next.dout = s_reg.wdata[tcu_pkg::PIN_BIT];
        end
      end
    end
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_full = 1'b1;
      s_next.awaddr  = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_full = 1'b1;
      s_next.wdata  = s_axi_wdata;
      s_next.wstrb  = s_axi_wstrb;
    end
    s_next.awready = !s_next.aw_full;
    s_next.wready  = !s_next.w_full;

    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = read_word(s_reg, s_axi_araddr[7:0]);
      s_next.rresp  = addr_mapped(s_axi_araddr[7:0]) ? tcu_pkg::RESP_OKAY
                                                      : tcu_pkg::RESP_SLVERR;
    end
    s_next.arready = !s_next.rvalid;

    // Capture: no read lock, a later event simply replaces the value.
    // Timer in asynchronous counter mode is sampled as is, not made coherent.
    if (cap_event) begin
      s_next.cap = companion_timer_count;  // RQ1 RQ6 RQ10
    end
    // Set beats clear; the enable plays no part in setting
    s_next.flag = (s_reg.flag && !clr_hit) || cap_event;  // RQ4 RQ13 RQ5

    s_next.pin_oe  = !s_next.dir;  // RQ8
    s_next.pin_out = s_next.dout;
    s_next.irq     = s_next.flag && s_next.ien;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= TOP_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready        = s_reg.awready;
  assign s_axi_wready         = s_reg.wready;
  assign s_axi_bvalid         = s_reg.bvalid;
  assign s_axi_bresp          = s_reg.bresp;
  assign s_axi_arready        = s_reg.arready;
  assign s_axi_rvalid         = s_reg.rvalid;
  assign s_axi_rdata          = s_reg.rdata;
  assign s_axi_rresp          = s_reg.rresp;
  assign capture_input_pin_o  = s_reg.pin_out;
  assign capture_input_pin_oe = s_reg.pin_oe;
  assign irq                  = s_reg.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_capture;
    cap_event;
  endsequence

  sequence seq_flag_kept;
    s_reg.flag && !clr_hit && !cap_event;
  endsequence

  // A capture that replaces a different value, whether read or not
  sequence seq_overwrite;
    cap_event && (s_reg.cap != companion_timer_count);
  endsequence

  a_capture_value: assert property (seq_capture |=> s_reg.cap == $past(companion_timer_count)) // RQ1
    else $error("capture register missed timer value");
  a_capture_overwrite: assert property (seq_overwrite // RQ6
                                        |=> s_reg.cap == $past(companion_timer_count))
    else $error("second capture did not overwrite");
  a_flag_set: assert property (seq_capture |=> s_reg.flag) // RQ4
    else $error("capture flag not set");
  a_flag_sticky: assert property (seq_flag_kept |=> s_reg.flag) // RQ5
    else $error("capture flag dropped without clear");
  // An enable write in the same cycle may legally drop the line
  a_irq_gate: assert property (s_reg.flag && s_reg.ien && !clr_hit // RQ13
                               && !(wr_do && s_reg.awaddr == tcu_pkg::OFS_ENABLE) |=> irq)
    else $error("enabled flag did not raise irq");
  a_drive_pin: assert property (wr_do && s_reg.wstrb[0] && s_reg.awaddr == tcu_pkg::OFS_DIR
                                |=> capture_input_pin_oe == !$past(s_reg.wdata[2])) // RQ8
    else $error("pin drive enable does not follow direction");
  a_bresp_hold: assert property (s_reg.bvalid && !s_axi_bready |=> s_reg.bvalid) // AXI4-Lite write response hold
    else $error("write response dropped early");

endmodule

// >>> tcu_pin_src.sv
/*
 * Model of the external source that drives the capture pin.
 * Assumes its tasks are called just after a rising edge of aclk.
 */
`timescale 1ns/1ps
module tcu_pin_src (
  input  wire logic aclk,
  input  wire logic oe,
  input  wire logic drv,
  output logic      pin
);
  // ****************************************
  // Pin level
  // ****************************************
  logic level_reg = 1'b0;

  // The device's own drive wins while it is enabled
  assign pin = oe ? drv : level_reg;

  // Three cycles per level, above the two-cycle minimum
  task automatic step(input logic lvl);
    level_reg <= lvl;
    repeat (3) @(posedge aclk);
  endtask

  task automatic pulse();
    step(1'b1);
    step(1'b0);
  endtask
endmodule

// >>> timer_capture_unit_tb_top.sv
/*
 * Self-checking bench of the capture unit over AXI4-Lite and the pin.
 * Assumes tcu_pkg, tcu_top and tcu_pin_src are compiled first.
 */
`timescale 1ns/1ps
module timer_capture_unit_tb_top;
  // ****************************************
  // Signals
  // ****************************************
  localparam logic [7:0]  CT = tcu_pkg::OFS_CTRL;
  localparam logic [7:0]  CP = tcu_pkg::OFS_CAPTURE;
  localparam logic [7:0]  ST = tcu_pkg::OFS_STATUS;
  localparam logic [7:0]  CL = tcu_pkg::OFS_CLEAR;
  localparam logic [7:0]  EN = tcu_pkg::OFS_ENABLE;
  localparam logic [7:0]  DR = tcu_pkg::OFS_DIR;
  localparam logic [7:0]  DT = tcu_pkg::OFS_DATA;
  localparam logic [31:0] Z  = 32'h0000_0000;
  localparam logic [31:0] O  = 32'h0000_0001;
  localparam logic [31:0] F  = 32'h0000_0004;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = Z;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [15:0] timer = 16'h0000;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp, brsp;
  logic [31:0] s_axi_rdata, rdat;
  logic        capture_input_pin_i, capture_input_pin_o, capture_input_pin_oe, irq;
  int          fails = 0;
  int          check_count = 0;
  int          b_lag = 0;

  always #5 aclk = ~aclk;

  tcu_top i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .companion_timer_count(timer),
    .capture_input_pin_i, .capture_input_pin_o, .capture_input_pin_oe, .irq
  );
  tcu_pin_src i_src (.aclk, .oe(capture_input_pin_oe), .drv(capture_input_pin_o),
    .pin(capture_input_pin_i));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Each channel drops its valid at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (b_lag == 0);
    // A late bready lets the response wait on the slave side
    do begin
      @(posedge aclk);
      n++;
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
      if (!s_axi_bready && n >= b_lag) begin
        s_axi_bready <= 1'b1;
      end
    end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
    brsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk("write wait", 32'(n >= 100), Z);
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
    end while (!s_axi_rvalid && n < 100);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("read wait", 32'(n >= 100), Z);
    @(posedge aclk);
  endtask

  task automatic see(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, rdat, e);
  endtask

  // Mask, let a false capture settle, then clear it
  task automatic set_mode(input logic [31:0] m);
    wr(EN, Z);
    wr(CT, m);
    idle(4);
    wr(CL, F);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    see(CT, Z, "ctrl");
    see(CP, Z, "capture");
    see(ST, Z, "status");
    see(EN, Z, "enable");
    see(DR, F, "dir");
    see(DT, Z, "data");
    chk("oe", 32'(capture_input_pin_oe), Z);
    see(8'h1C, Z, "unmapped rdata");
    chk("unmapped rresp", 32'(rrsp), 32'(tcu_pkg::RESP_SLVERR));
    b_lag = 4;
    wr(8'h1C, 32'hFFFF_FFFF);
    b_lag = 0;
    chk("unmapped bresp", 32'(brsp), 32'(tcu_pkg::RESP_SLVERR));
  endtask

  task automatic t_modes();
    int need [4] = '{1, 1, 4, 16};
    for (int i = 0; i < 4; i++) begin
      set_mode(32'(tcu_pkg::MODE_FALL + 4'(i)));
      timer <= {4'(i + 4), 12'hA5C};
      repeat (need[i] - 1) i_src.pulse();
      idle(4);
      see(ST, Z, "early flag");
      i_src.step(1'b1);
      idle(3);
      see(ST, (i > 0) ? F : Z, "rise flag");
      i_src.step(1'b0);
      idle(3);
      see(ST, F, "fall flag");
      see(CP, {16'h0000, 4'(i + 4), 12'hA5C}, "capture");
    end
    set_mode(Z);
    i_src.pulse();
    idle(4);
    see(ST, Z, "off flag");
  endtask

  task automatic t_overwrite();
    set_mode(32'(tcu_pkg::MODE_RISE));
    timer <= 16'h1357;
    i_src.pulse();
    see(ST, F, "flag unenabled");
    chk("irq masked", 32'(irq), Z);
    see(CP, 32'h0000_1357, "first capture");
    timer <= 16'hC0DE;
    i_src.pulse();
    see(CP, 32'h0000_C0DE, "overwrite");
    idle(20);
    wr(ST, Z);
    wr(CP, Z);
    see(ST, F, "sticky");
    see(CP, 32'h0000_C0DE, "capture ro");
    wr(EN, F);
    chk("irq on", 32'(irq), O);
    wr(EN, Z);
    chk("irq off", 32'(irq), Z);
    wr(EN, F);
    wr(CL, F);
    see(ST, Z, "cleared");
    chk("irq cleared", 32'(irq), Z);
  endtask

  task automatic t_port();
    wr(DT, Z);
    wr(DR, Z);
    chk("oe on", 32'(capture_input_pin_oe), O);
    set_mode(32'(tcu_pkg::MODE_RISE));
    timer <= 16'h8421;
    wr(DT, F);
    chk("pin out", 32'(capture_input_pin_o), O);
    see(ST, F, "port flag");
    see(CP, 32'h0000_8421, "port capture");
    wr(DR, F);
    chk("oe off", 32'(capture_input_pin_oe), Z);
  endtask

  task automatic results();
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_modes();
    t_overwrite();
    t_port();
    results();
  end

  // Whole run needs well under 10k cycles
  initial begin
    #500us;
    fails++;
    $display("ERROR watchdog expected done seen hang");
    results();
  end
endmodule
